/* csw_pkg.sv */
// Constants and carrier types for the control switch and user button block.
// Assumes an APB master with 12-bit byte addresses and 32-bit data.
package csw_pkg;

  // Sizes
  localparam int NUM_SW = 5;
  localparam int NUM_BTN = 12;
  localparam int NAME_CHARS = 32;
  localparam int NAME_WORDS_PER_SW = NAME_CHARS / 4;
  localparam int NAME_WORDS = NUM_SW * NAME_WORDS_PER_SW;
  localparam logic [5:0] NAME_WORDS_W = 6'h28;
  localparam logic [2:0] NUM_SW_W = 3'h5;

  // Register offsets
  localparam logic [11:0] OFF_SW_STATE = 12'h000;
  localparam logic [11:0] OFF_EVT_SEL = 12'h004;
  localparam logic [11:0] OFF_PANEL_LEVEL = 12'h008;
  localparam logic [11:0] OFF_BTN_MODE = 12'h00C;
  localparam logic [11:0] OFF_BTN_STATUS = 12'h010;
  localparam logic [11:0] OFF_LED_COLOR = 12'h014;
  localparam logic [11:0] OFF_LED_SRC = 12'h018;
  localparam logic [11:0] OFF_IRQ_STATUS = 12'h01C;
  localparam logic [11:0] OFF_IRQ_MASK = 12'h020;
  localparam logic [11:0] OFF_TIMESTAMP = 12'h024;
  localparam logic [3:0] NAME_PAGE = 4'h1;

  // Field positions: event select and irq share layout, on in low half
  localparam int ON_LSB = 0;
  localparam int OFF_LSB = 5;

  // Reset values
  localparam logic [9:0] RST_EVT_SEL = 10'h3FF;
  localparam logic [11:0] RST_BTN_MODE = 12'h000;
  localparam logic [23:0] RST_LED_COLOR = 24'h555555;
  localparam logic [11:0] RST_LED_SRC = 12'h000;
  localparam logic [9:0] RST_IRQ_MASK = 10'h000;

  typedef enum logic [1:0] {LVL_USER, LVL_OPERATOR, LVL_CONFIGURATOR, LVL_SUPER} access_level_t;
  localparam access_level_t RST_PANEL_LEVEL = LVL_CONFIGURATOR;

  typedef enum logic [1:0] {LED_OFF, LED_RED, LED_ORANGE, LED_GREEN} led_color_t;

  typedef struct packed {
    logic valid;
    logic [2:0] sw;
    logic activate;
  } cmd_t;

  typedef struct packed {
    logic valid;
    logic [2:0] sw;
    logic on;
    logic [31:0] stamp;
  } evt_t;

endpackage

/* control_switch_and_user_buttons.sv */
// Latching control switches, front-panel user buttons, events and APB registers.
// Assumes panel and remote commands on pclk; button pins are asynchronous.
`timescale 1ns/100ps
`default_nettype none

module control_switch_and_user_buttons (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Switch commands
  input wire csw_pkg::cmd_t panel_cmd,
  input wire csw_pkg::access_level_t panel_level,
  input wire csw_pkg::cmd_t remote_cmd,
  output logic cmd_ready,
  // Switch outputs and events
  output logic [4:0] switch_out,
  output csw_pkg::evt_t event_rec,
  // User buttons
  input wire logic [11:0] button_pin,
  input wire logic [11:0] led_alt_src,
  output logic [11:0] btn_on,
  output logic [11:0] btn_off,
  output logic [11:0] led_red,
  output logic [11:0] led_orange,
  output logic [11:0] led_green,
  // Interrupt
  output logic irq
);

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [4:0] sw;
    logic [9:0] evt_sel;
    csw_pkg::access_level_t min_level;
    logic [9:0] pend;
    logic [31:0] stamp;
    logic ready;
    csw_pkg::evt_t evt;
    logic [31:0] tstamp;
    logic [11:0] sync1;
    logic [11:0] sync2;
    logic [11:0] sync3;
    logic [11:0] btn_lvl;
    logic [11:0] btn_mode;
    logic [11:0] status;
    logic [11:0] status_n;
    logic [23:0] led_color;
    logic [11:0] led_src;
    logic [11:0] red;
    logic [11:0] orange;
    logic [11:0] green;
    logic [9:0] irq_status;
    logic [9:0] irq_mask;
    logic irq;
    logic [csw_pkg::NAME_WORDS-1:0][31:0] name;
  } state_t;

  state_t s_q;
  state_t s_d;
  logic panel_ok;
  logic remote_ok;
  logic [4:0] sw_next;
  logic [4:0] rise;
  logic [4:0] fall;
  logic [11:0] press;
  logic [9:0] pend_left;
  logic [3:0] pick;
  logic pick_found;
  logic rd_access;
  logic wr_commit;
  logic name_hit;
  logic reg_hit;
  logic [31:0] rd_val;
  logic led_drive;
  logic [1:0] led_col;

  always_comb begin
    s_d = s_q;
    panel_ok = 1'b0;
    remote_ok = 1'b0;
    sw_next = s_q.sw;
    press = 12'h000;
    pend_left = s_q.pend;
    pick = 4'h0;
    pick_found = 1'b0;
    rd_val = 32'h0000_0000;
    led_drive = 1'b0;
    led_col = 2'h0;
    s_d.tstamp = s_q.tstamp + 32'h0000_0001;

    // Button pins: three stages, a change counts once stages two and three agree
    s_d.sync1 = button_pin;
    s_d.sync2 = s_q.sync1;
    s_d.sync3 = s_q.sync2;
    for (int i = 0; i < csw_pkg::NUM_BTN; i++) begin
      if (s_q.sync2[i] == s_q.sync3[i]) begin
        s_d.btn_lvl[i] = s_q.sync3[i];
      end
    end
    press = s_d.btn_lvl & ~s_q.btn_lvl;

    for (int i = 0; i < csw_pkg::NUM_BTN; i++) begin
      if (s_q.btn_mode[i]) begin
        if (press[i]) begin
          s_d.status[i] = ~s_q.status[i];
        end
      end else begin
        s_d.status[i] = s_d.btn_lvl[i];
      end
    end
    s_d.status_n = ~s_d.status;

    for (int i = 0; i < csw_pkg::NUM_BTN; i++) begin
      led_drive = s_q.led_src[i] ? led_alt_src[i] : s_d.status[i];
      led_col = s_q.led_color[2*i +: 2];
      s_d.red[i] = led_drive && (led_col == csw_pkg::LED_RED);
      s_d.orange[i] = led_drive && (led_col == csw_pkg::LED_ORANGE);
      s_d.green[i] = led_drive && (led_col == csw_pkg::LED_GREEN);
    end

    // Only panel and remote ports command
    panel_ok = s_q.ready && panel_cmd.valid && (panel_cmd.sw < csw_pkg::NUM_SW_W)
               && (panel_level >= s_q.min_level);
    remote_ok = s_q.ready && remote_cmd.valid && (remote_cmd.sw < csw_pkg::NUM_SW_W)
                && !(panel_ok && (panel_cmd.sw == remote_cmd.sw));
    if (panel_ok) begin
      sw_next[panel_cmd.sw] = panel_cmd.activate;
    end
    if (remote_ok) begin
      sw_next[remote_cmd.sw] = remote_cmd.activate;
    end
    s_d.sw = sw_next;
    rise = sw_next & ~s_q.sw;
    fall = s_q.sw & ~sw_next;

    // Drain one pending event a cycle, lowest index first
    s_d.evt.valid = 1'b0;
    for (int i = 9; i >= 0; i--) begin
      if (s_q.pend[i]) begin
        pick = i[3:0];
        pick_found = 1'b1;
      end
    end
    if (pick_found) begin
      pend_left[pick] = 1'b0;
      s_d.evt.valid = 1'b1;
      s_d.evt.on = (pick < 4'h5);
      s_d.evt.sw = (pick < 4'h5) ? pick[2:0] : 3'(pick - 4'h5);
      s_d.evt.stamp = s_q.stamp;
    end
    s_d.pend = pend_left | {fall & s_q.evt_sel[9:5], rise & s_q.evt_sel[4:0]};
    // One shared stamp is enough: commands wait until the queue is empty
    if ((rise | fall) != 5'h00) begin
      s_d.stamp = s_q.tstamp;
    end
    s_d.ready = (s_d.pend == 10'h000);

    // APB: answer one cycle into the access phase
    rd_access = psel && penable && !s_q.pready;
    wr_commit = psel && penable && s_q.pready && pwrite && !s_q.pslverr;
    name_hit = (paddr[11:8] == csw_pkg::NAME_PAGE) && (paddr[7:2] < csw_pkg::NAME_WORDS_W);
    reg_hit = 1'b1;
    case (paddr)
      csw_pkg::OFF_SW_STATE: rd_val = {27'h0, s_q.sw};
      csw_pkg::OFF_EVT_SEL: rd_val = {22'h0, s_q.evt_sel};
      csw_pkg::OFF_PANEL_LEVEL: rd_val = {30'h0, s_q.min_level};
      csw_pkg::OFF_BTN_MODE: rd_val = {20'h0, s_q.btn_mode};
      csw_pkg::OFF_BTN_STATUS: rd_val = {20'h0, s_q.status};
      csw_pkg::OFF_LED_COLOR: rd_val = {8'h0, s_q.led_color};
      csw_pkg::OFF_LED_SRC: rd_val = {20'h0, s_q.led_src};
      csw_pkg::OFF_IRQ_STATUS: rd_val = {22'h0, s_q.irq_status};
      csw_pkg::OFF_IRQ_MASK: rd_val = {22'h0, s_q.irq_mask};
      csw_pkg::OFF_TIMESTAMP: rd_val = s_q.tstamp;
      default: begin
        reg_hit = name_hit && (paddr[1:0] == 2'h0);
        rd_val = reg_hit ? s_q.name[paddr[7:2]] : 32'h0000_0000;
      end
    endcase
    s_d.pready = rd_access;
    s_d.pslverr = rd_access && !reg_hit;
    if (rd_access && !pwrite) begin
      s_d.prdata = rd_val;
    end

    // Set wins over a same-cycle write-one-to-clear
    s_d.irq_status = s_q.irq_status;
    if (wr_commit) begin
      case (paddr)
        csw_pkg::OFF_EVT_SEL: s_d.evt_sel = pwdata[9:0];
        csw_pkg::OFF_PANEL_LEVEL: s_d.min_level = csw_pkg::access_level_t'(pwdata[1:0]);
        csw_pkg::OFF_BTN_MODE: s_d.btn_mode = pwdata[11:0];
        csw_pkg::OFF_LED_COLOR: s_d.led_color = pwdata[23:0];
        csw_pkg::OFF_LED_SRC: s_d.led_src = pwdata[11:0];
        csw_pkg::OFF_IRQ_STATUS: s_d.irq_status = s_q.irq_status & ~pwdata[9:0];
        csw_pkg::OFF_IRQ_MASK: s_d.irq_mask = pwdata[9:0];
        default: begin
          if (name_hit) begin
            s_d.name[paddr[7:2]] = pwdata;
          end
        end
      endcase
    end
    s_d.irq_status = s_d.irq_status | {fall, rise};
    s_d.irq = (s_d.irq_status & s_d.irq_mask) != 10'h000;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
      s_q.ready <= 1'b1;
      s_q.evt_sel <= csw_pkg::RST_EVT_SEL;
      s_q.min_level <= csw_pkg::RST_PANEL_LEVEL;
      s_q.btn_mode <= csw_pkg::RST_BTN_MODE;
      s_q.status_n <= 12'hFFF;
      s_q.led_color <= csw_pkg::RST_LED_COLOR;
      s_q.led_src <= csw_pkg::RST_LED_SRC;
      s_q.irq_mask <= csw_pkg::RST_IRQ_MASK;
    end else begin
      s_q <= s_d;
    end
  end

  assign prdata = s_q.prdata;
  assign pready = s_q.pready;
  assign pslverr = s_q.pslverr;
  assign cmd_ready = s_q.ready;
  assign switch_out = s_q.sw;
  assign event_rec = s_q.evt;
  assign btn_on = s_q.status;
  assign btn_off = s_q.status_n;
  assign led_red = s_q.red;
  assign led_orange = s_q.orange;
  assign led_green = s_q.green;
  assign irq = s_q.irq;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // Checks read registered state, so they see what the logic saw at each edge
  a_switch_hold: assert property (!panel_ok && !remote_ok |=> $stable(switch_out))
    else $error("switch changed without a command");
  a_remote_only: assert property (
    !remote_ok && !panel_ok && !s_q.pready |=> $stable(s_q.sw))
    else $error("switch changed from a non-command source");
  a_panel_level: assert property (
    panel_cmd.valid && (panel_level < s_q.min_level) && !remote_ok |=> $stable(switch_out))
    else $error("panel command below access level took effect");
  a_same_state: assert property (
    panel_ok && !remote_ok && (s_q.sw[panel_cmd.sw] == panel_cmd.activate)
    |=> s_q.pend == 10'h000 && cmd_ready)
    else $error("same-state command produced an event");
  a_event_stamp: assert property (
    ((rise & s_q.evt_sel[4:0]) != 5'h00)
    |=> s_q.stamp == $past(s_q.tstamp) ##1 event_rec.valid && event_rec.on)
    else $error("stored event missing or stamp wrong");
  a_stamp_hold: assert property ((rise | fall) == 5'h00 |=> $stable(s_q.stamp))
    else $error("stamp moved without a switch change");
  a_off_event: assert property (
    ((fall & s_q.evt_sel[9:5]) != 5'h00) && (rise == 5'h00)
    |-> ##2 event_rec.valid && !event_rec.on)
    else $error("OFF event not emitted");
  a_event_pulse: assert property (
    event_rec.valid && s_q.pend == 10'h000 |=> !event_rec.valid)
    else $error("event pulse longer than one cycle");
  a_unselected: assert property (
    ((rise | fall) != 5'h00) && (s_q.evt_sel == 10'h000) |=> cmd_ready ##1 !event_rec.valid)
    else $error("unselected event stored");
  a_irq_set: assert property (
    (rise | fall) != 5'h00
    |=> (s_q.irq_status & {$past(fall), $past(rise)}) == {$past(fall), $past(rise)})
    else $error("switch change did not set its status bit");
  a_momentary_level: assert property (
    $stable(s_q.btn_mode) |-> ((btn_on ^ s_q.btn_lvl) & ~s_q.btn_mode) == 12'h000)
    else $error("momentary status differs from button level");
  a_toggle_press: assert property (
    $stable(s_q.btn_mode)
    |-> ((btn_on ^ $past(btn_on) ^ (s_q.btn_lvl & ~$past(s_q.btn_lvl)))
    & s_q.btn_mode) == 12'h000)
    else $error("toggle status did not invert exactly on a press");
  a_button_only: assert property (
    $stable(s_q.btn_mode)
    |-> ((btn_on ^ $past(btn_on)) & ~(s_q.btn_lvl ^ $past(s_q.btn_lvl))) == 12'h000)
    else $error("button status changed without a pin change");
  a_led_source: assert property (
    $past(s_q.led_src) == 12'h000
    |-> ((led_red | led_orange | led_green) & ~btn_on) == 12'h000)
    else $error("LED lit without its button status");
  a_off_complement: assert property (btn_off == ~btn_on)
    else $error("off status is not the complement of on");
  a_apb_answer: assert property (psel && penable && !pready |=> pready ##1 !pready)
    else $error("APB answer not one cycle into access");

  c_switch_on: cover property (panel_ok ##1 $rose(switch_out[1]) ##1 event_rec.valid);
  c_toggle: cover property (s_q.btn_mode[1] && $rose(btn_on[1]));
  c_both_cmds: cover property (panel_ok && remote_ok);
  c_irq: cover property ($rose(irq));
  c_unselected: cover property ((rise | fall) != 5'h00 && s_q.evt_sel == 10'h000);

endmodule

`default_nettype wire

/* dummy_end_marker_not_used.sv */
`timescale 1ns/100ps
`default_nettype none
`default_nettype wire

/* csw_partner.sv */
// Model of the local panel and the remote terminal sending switch commands.
// Assumes pclk from the bench and cmd_ready from the block.
`timescale 1ns/100ps
`default_nettype none

module csw_partner (
  // Clock
  input wire logic pclk,
  // Command handshake
  input wire logic cmd_ready,
  output csw_pkg::cmd_t panel_cmd,
  output csw_pkg::cmd_t remote_cmd
);
  initial begin
    panel_cmd = '0;
    remote_cmd = '0;
  end

  task automatic send(input logic remote, input logic [2:0] sw, input logic act);
    csw_pkg::cmd_t c;
    c = '{valid: 1'b1, sw: sw, activate: act};
    @(posedge pclk);
    if (remote) begin
      remote_cmd <= c;
    end else begin
      panel_cmd <= c;
    end
    // Held until a rising edge samples cmd_ready high; the bench watchdog ends a hang
    do begin
      @(posedge pclk);
    end while (cmd_ready !== 1'b1);
    // Released fields flip so a stale value is never mistaken for a held one
    c = '{valid: 1'b0, sw: ~sw, activate: ~act};
    panel_cmd <= c;
    remote_cmd <= c;
  endtask
endmodule

`default_nettype wire

/* tb_control_switch_and_user_buttons.sv */
// Self-checking bench for the control switch and user button block.
// Assumes the partner model drives commands; the bench is APB master.
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, s) begin comparisons++; if ((s) !== (e)) begin errors++; \
  $display("wrong value %s exp %h seen %h", n, e, s); end end

module tb_control_switch_and_user_buttons;
  logic pclk = 0;
  logic presetn = 0;
  logic psel = 0;
  logic penable = 0;
  logic pwrite = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  csw_pkg::cmd_t panel_cmd;
  csw_pkg::cmd_t remote_cmd;
  csw_pkg::access_level_t panel_level = csw_pkg::LVL_CONFIGURATOR;
  logic cmd_ready;
  logic [4:0] switch_out;
  csw_pkg::evt_t event_rec;
  logic [11:0] button_pin = '0;
  logic [11:0] led_alt_src = '0;
  logic [11:0] btn_on;
  logic [11:0] btn_off;
  logic [11:0] led_red;
  logic [11:0] led_orange;
  logic [11:0] led_green;
  logic irq;
  logic [31:0] rd;
  logic err;
  int errors = 0;
  int comparisons = 0;

  control_switch_and_user_buttons control_switch_and_user_buttons_i (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .panel_cmd(panel_cmd), .panel_level(panel_level), .remote_cmd(remote_cmd),
    .cmd_ready(cmd_ready), .switch_out(switch_out), .event_rec(event_rec),
    .button_pin(button_pin), .led_alt_src(led_alt_src), .btn_on(btn_on),
    .btn_off(btn_off), .led_red(led_red), .led_orange(led_orange),
    .led_green(led_green), .irq(irq));
  csw_partner csw_partner_i (.pclk(pclk), .cmd_ready(cmd_ready), .panel_cmd(panel_cmd),
    .remote_cmd(remote_cmd));

  initial begin
    forever #20 pclk = ~pclk;
  end

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Pready is read at the edge that ends the access; only the watchdog ends a hang
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // One more edge so a write has landed before the caller looks
    @(posedge pclk);
  endtask

  // Pulse is one cycle wide, so look at every cycle
  task automatic evt(input logic [2:0] sw, input logic on, input logic want);
    int n;
    logic got;
    csw_pkg::evt_t e;
    got = 1'b0;
    e = '0;
    for (n = 0; n < 12; n++) begin
      @(posedge pclk);
      if (event_rec.valid === 1'b1 && !got) begin
        got = 1'b1;
        e = event_rec;
      end
    end
    `CHK("event seen", want, got)
    if (want) begin
      `CHK("event sw", sw, e.sw)
      `CHK("event on", on, e.on)
      `CHK("event stamp set", 1'b1, e.stamp !== 32'h0)
    end
  endtask

  task automatic t_regs;
    apb(1'b0, csw_pkg::OFF_EVT_SEL, '0);
    `CHK("evt_sel", 32'h000003FF, rd)
    apb(1'b0, csw_pkg::OFF_PANEL_LEVEL, '0);
    `CHK("panel level", 32'h00000002, rd)
    apb(1'b0, csw_pkg::OFF_BTN_MODE, '0);
    `CHK("btn mode", 32'h00000000, rd)
    apb(1'b0, csw_pkg::OFF_LED_COLOR, '0);
    `CHK("led color", 32'h00555555, rd)
    apb(1'b1, csw_pkg::OFF_BTN_STATUS, 32'h00000FFF);
    apb(1'b0, csw_pkg::OFF_BTN_STATUS, '0);
    `CHK("btn status ro", 32'h00000000, rd)
    apb(1'b0, 12'h0FC, '0);
    `CHK("unmapped err", 1'b1, err)
    apb(1'b1, 12'h13C, 32'h00004E31);
    apb(1'b0, 12'h13C, '0);
    `CHK("name word", 32'h00004E31, rd)
    apb(1'b0, 12'h1A0, '0);
    `CHK("name past end", 1'b1, err)
  endtask

  task automatic t_panel;
    csw_partner_i.send(1'b0, 3'h1, 1'b1);
    @(posedge pclk);
    `CHK("busy after accept", 1'b0, cmd_ready)
    evt(3'h1, 1'b1, 1'b1);
    `CHK("sw on", 5'h02, switch_out)
    csw_partner_i.send(1'b0, 3'h1, 1'b1);
    evt(3'h1, 1'b1, 1'b0);
    panel_level <= csw_pkg::LVL_USER;
    csw_partner_i.send(1'b0, 3'h1, 1'b0);
    evt(3'h1, 1'b0, 1'b0);
    `CHK("sw held", 5'h02, switch_out)
    panel_level <= csw_pkg::LVL_SUPER;
    csw_partner_i.send(1'b0, 3'h1, 1'b0);
    evt(3'h1, 1'b0, 1'b1);
    csw_partner_i.send(1'b1, 3'h5, 1'b1);
    evt(3'h5, 1'b1, 1'b0);
  endtask

  task automatic t_all;
    int i;
    for (i = 0; i < 5; i++) begin
      csw_partner_i.send(1'b1, i[2:0], 1'b1);
      evt(i[2:0], 1'b1, 1'b1);
      `CHK("one sw on", 5'h01 << i, switch_out)
      csw_partner_i.send(1'b1, i[2:0], 1'b0);
      evt(i[2:0], 1'b0, 1'b1);
    end
    apb(1'b0, csw_pkg::OFF_IRQ_STATUS, '0);
    `CHK("irq status", 32'h000003FF, rd)
    `CHK("irq masked", 1'b0, irq)
    apb(1'b1, csw_pkg::OFF_IRQ_MASK, 32'h00000001);
    `CHK("irq up", 1'b1, irq)
    apb(1'b1, csw_pkg::OFF_IRQ_STATUS, 32'h000003FF);
    `CHK("irq cleared", 1'b0, irq)
    apb(1'b1, csw_pkg::OFF_EVT_SEL, 32'h0000001F);
    csw_partner_i.send(1'b1, 3'h4, 1'b1);
    evt(3'h4, 1'b1, 1'b1);
    csw_partner_i.send(1'b1, 3'h4, 1'b0);
    evt(3'h4, 1'b0, 1'b0);
    apb(1'b1, csw_pkg::OFF_EVT_SEL, 32'h00000000);
    csw_partner_i.send(1'b1, 3'h3, 1'b1);
    evt(3'h3, 1'b1, 1'b0);
    `CHK("unstored sw on", 5'h08, switch_out)
  endtask

  task automatic t_buttons;
    button_pin <= 12'h001;
    repeat (8) @(posedge pclk);
    `CHK("momentary on", 1'b1, btn_on[0])
    `CHK("off is inverse", 12'hFFE, btn_off)
    `CHK("led follows", 1'b1, led_red[0])
    button_pin <= 12'h000;
    repeat (8) @(posedge pclk);
    `CHK("momentary off", 1'b0, btn_on[0])
    apb(1'b1, csw_pkg::OFF_BTN_MODE, 32'h00000002);
    apb(1'b1, csw_pkg::OFF_LED_SRC, 32'h00000004);
    led_alt_src <= 12'h004;
    button_pin <= 12'h002;
    repeat (8) @(posedge pclk);
    button_pin <= 12'h000;
    repeat (8) @(posedge pclk);
    `CHK("toggle held", 12'h002, btn_on)
    `CHK("alt led", 1'b1, led_red[2])
    button_pin <= 12'h002;
    repeat (8) @(posedge pclk);
    `CHK("toggle off", 1'b0, btn_on[1])
    apb(1'b1, csw_pkg::OFF_LED_COLOR, 32'h00000038);
    repeat (2) @(posedge pclk);
    `CHK("alt led green", 1'b1, led_green[2])
    button_pin <= 12'h000;
    repeat (8) @(posedge pclk);
    button_pin <= 12'h002;
    repeat (8) @(posedge pclk);
    `CHK("toggle led orange", 1'b1, led_orange[1])
  endtask

  task automatic close_out;
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_panel();
    t_all();
    t_buttons();
    close_out();
  end

  // Whole run needs a few hundred cycles
  initial begin
    repeat (20000) @(posedge pclk);
    errors++;
    close_out();
  end
endmodule

`default_nettype wire
